/* File: hw/blsf_defs.svh */
`ifndef BLSF_DEFS_SVH
`define BLSF_DEFS_SVH

// bus address, 7-bit form
`define BLSF_SLAVE_ADDR 7'h2C

// register pointer values
`define BLSF_REG_COMMAND 8'h00
`define BLSF_REG_FAULT 8'h01
`define BLSF_REG_MASK 8'h02
`define BLSF_REG_BRT_LO 8'h03
`define BLSF_REG_BRT_HI 8'h04
`define BLSF_REG_CONFIG 8'h10

// field positions and masks
`define BLSF_CMD_ON_BIT 0
`define BLSF_CMD_RESET_BIT 7
`define BLSF_CMD_MASK 8'h07
`define BLSF_MASK_MASK 8'h1F
`define BLSF_BRT_LO_MASK 8'h0F
`define BLSF_CFG_PWM_LOW_STANDBY_ENABLE_BIT 7
`define BLSF_CFG_PSD_BIT 5
`define BLSF_CFG_MODE_MSB 1
`define BLSF_CFG_MODE_LSB 0
`define BLSF_CFG_MODE_PWM_ONLY 2'h0

// reset values
`define BLSF_CMD_RST 8'h00
`define BLSF_CFG_RST 8'h00
`define BLSF_MASK_RST 8'h00
`define BLSF_BRT_RST 12'h000

// timing
`define BLSF_CLK_MHZ 125
`define BLSF_BOOST_UNDERVOLTAGE_FLAG_TIME_US 6000
`define BLSF_BOOST_UNDERVOLTAGE_FLAG_CYCLES (`BLSF_BOOST_UNDERVOLTAGE_FLAG_TIME_US * `BLSF_CLK_MHZ)

`endif

/* File: hw/blsf_pkg.sv */
package blsf_pkg;

    typedef enum logic [1:0] {
        BLSF_MODE_LOAD = 2'b00,
        BLSF_MODE_STANDBY = 2'b01,
        BLSF_MODE_ACTIVE = 2'b10
    } blsf_mode_t;

    typedef enum logic [2:0] {
        BLSF_BUS_IDLE = 3'b000,
        BLSF_BUS_ADDR = 3'b001,
        BLSF_BUS_RX = 3'b010,
        BLSF_BUS_ACK = 3'b011,
        BLSF_BUS_TX = 3'b100,
        BLSF_BUS_MACK = 3'b101
    } blsf_bus_t;

    // bit order matches the fault status register, bit 4 down to bit 0
    typedef struct packed {
        logic boost_undervoltage_flag;
        logic boost_overvoltage_flag;
        logic boost_overcurrent_flag;
        logic thermal_trip_flag;
        logic supply_undervoltage_flag;
    } blsf_faults_t;

    typedef struct packed {
        logic chip_en;
        logic supply_low;
        logic supply_high;
        logic temp_trip;
        logic temp_release;
        logic boost_ilim;
        logic boost_clamp;
        logic boost_low;
        logic pwm;
    } blsf_mon_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } blsf_pins_t;

    typedef struct packed {
        blsf_mode_t mode;
        blsf_faults_t faults;
        logic uv_block;
        logic therm_block;
        logic [19:0] uv_cnt;
        logic pwm_seen;
        logic [7:0] cmd;
        logic [7:0] cfg;
        logic [7:0] mask;
        logic [11:0] brt;
        logic [1:0] clamp_sel;
        blsf_bus_t bus;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic byte_full;
        logic rw;
        logic ptr_phase;
        logic [7:0] ptr;
        logic scl_prev;
        logic sda_prev;
        logic sda_oe_n;
        logic sda_o;
        logic backlight_en;
    } blsf_state_t;

endpackage

/* File: hw/blsf_sync.sv */
`timescale 1ns/1ps
module blsf_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } blsf_sync_state_t;

    blsf_sync_state_t s_r;
    blsf_sync_state_t s_nxt;

    // a bit moves only once stages two and three agree
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = i_async;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.stable = (~(s_r.s2 ^ s_r.s3) & s_r.s3) | ((s_r.s2 ^ s_r.s3) & s_r.stable);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_stable = s_r.stable;
endmodule

/* File: hw/blsf_top.sv */
`timescale 1ns/1ps
`include "blsf_defs.svh"
module blsf_top #(
    parameter logic [19:0] P_BOOST_UNDERVOLTAGE_FLAG_CYCLES = 20'(`BLSF_BOOST_UNDERVOLTAGE_FLAG_CYCLES)
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_enable_supply_pin,
    input wire logic i_serial_clock_line_pin,
    input wire logic i_serial_data_line_pin,
    output logic o_serial_data_line_pin_o,
    output logic o_serial_data_line_pin_oe_n,
    input wire logic i_pwm,
    input wire logic i_supply_low,
    input wire logic i_supply_above_hyst,
    input wire logic i_temp_trip,
    input wire logic i_temp_below_release,
    input wire logic i_boost_ilim,
    input wire logic i_boost_clamp,
    input wire logic i_boost_low,
    input wire logic [7:0] i_nv_command,
    input wire logic [7:0] i_nv_config,
    input wire logic [1:0] i_nv_clamp_sel,
    output logic o_backlight_en,
    output logic [1:0] o_mode,
    output logic [4:0] o_faults,
    output logic [11:0] o_brightness,
    output logic [1:0] o_boost_clamp_sel,
    output logic o_phase_shifted_dimming
);
    blsf_pkg::blsf_mon_t mon_raw;
    blsf_pkg::blsf_mon_t mon;
    blsf_pkg::blsf_pins_t pins_raw;
    blsf_pkg::blsf_pins_t pins;
    blsf_pkg::blsf_state_t s_r;
    blsf_pkg::blsf_state_t s_nxt;
    blsf_pkg::blsf_faults_t fault_set;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic active_req;
    logic bus_ctrl;
    logic pwm_low_standby_enable;
    logic load_tx;
    logic wr_en;
    logic clear_faults;
    logic soft_reset;
    logic [7:0] rd_byte;

    assign mon_raw.chip_en = i_chip_enable_supply_pin;
    assign mon_raw.supply_low = i_supply_low;
    assign mon_raw.supply_high = i_supply_above_hyst;
    assign mon_raw.temp_trip = i_temp_trip;
    assign mon_raw.temp_release = i_temp_below_release;
    assign mon_raw.boost_ilim = i_boost_ilim;
    assign mon_raw.boost_clamp = i_boost_clamp;
    assign mon_raw.boost_low = i_boost_low;
    assign mon_raw.pwm = i_pwm;
    assign pins_raw.scl = i_serial_clock_line_pin;
    assign pins_raw.sda = i_serial_data_line_pin;

    blsf_sync #(
        .W($bits(blsf_pkg::blsf_mon_t))
    ) u_sync_mon (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(mon_raw),
        .o_stable(mon)
    );

    blsf_sync #(
        .W($bits(blsf_pkg::blsf_pins_t))
    ) u_sync_pins (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(pins_raw),
        .o_stable(pins)
    );

    function automatic logic [7:0] read_reg(input blsf_pkg::blsf_state_t s);
        logic [7:0] v;
        v = 8'h00;
        if (s.ptr == `BLSF_REG_COMMAND) begin
            v = s.cmd;
        end else if (s.ptr == `BLSF_REG_FAULT) begin
            v = {3'h0, s.faults};
        end else if (s.ptr == `BLSF_REG_MASK) begin
            v = s.mask;
        end else if (s.ptr == `BLSF_REG_BRT_LO) begin
            v = {4'h0, s.brt[3:0]};
        end else if (s.ptr == `BLSF_REG_BRT_HI) begin
            v = s.brt[11:4];
        end else if (s.ptr == `BLSF_REG_CONFIG) begin
            v = s.cfg;
        end
        return v;
    endfunction

    assign bus_ctrl = (s_r.cfg[`BLSF_CFG_MODE_MSB:`BLSF_CFG_MODE_LSB] != `BLSF_CFG_MODE_PWM_ONLY);
    assign pwm_low_standby_enable = s_r.cfg[`BLSF_CFG_PWM_LOW_STANDBY_ENABLE_BIT];
    assign active_req = bus_ctrl ? s_r.cmd[`BLSF_CMD_ON_BIT] : s_r.pwm_seen;

    always_comb begin
        s_nxt = s_r;
        load_tx = 1'b0;
        wr_en = 1'b0;
        clear_faults = 1'b0;
        soft_reset = 1'b0;
        rd_byte = read_reg(s_r);
        scl_rise = pins.scl & ~s_r.scl_prev;
        scl_fall = ~pins.scl & s_r.scl_prev;
        start_c = s_r.scl_prev & pins.scl & s_r.sda_prev & ~pins.sda;
        stop_c = s_r.scl_prev & pins.scl & ~s_r.sda_prev & pins.sda;
        s_nxt.scl_prev = pins.scl;
        s_nxt.sda_prev = pins.sda;
        s_nxt.sda_o = 1'b0;

        // pwm duty seen starts the backlight in pwm-only operation
        if (mon.pwm) begin
            s_nxt.pwm_seen = 1'b1;
        end else if (pwm_low_standby_enable) begin
            s_nxt.pwm_seen = 1'b0;
        end

        case (s_r.mode)
            blsf_pkg::BLSF_MODE_LOAD: begin
                s_nxt.cmd = i_nv_command & `BLSF_CMD_MASK;
                s_nxt.cfg = i_nv_config;
                s_nxt.clamp_sel = i_nv_clamp_sel;
                s_nxt.mode = blsf_pkg::BLSF_MODE_STANDBY;
            end
            blsf_pkg::BLSF_MODE_STANDBY: begin
                if (active_req) begin
                    s_nxt.mode = blsf_pkg::BLSF_MODE_ACTIVE;
                end
            end
            blsf_pkg::BLSF_MODE_ACTIVE: begin
                if (!active_req) begin
                    s_nxt.mode = blsf_pkg::BLSF_MODE_STANDBY;
                end
            end
            default: begin
                s_nxt.mode = blsf_pkg::BLSF_MODE_LOAD;
            end
        endcase

        // protection blocks with hysteresis
        if (mon.supply_low) begin
            s_nxt.uv_block = 1'b1;
        end else if (mon.supply_high) begin
            s_nxt.uv_block = 1'b0;
        end
        if (mon.temp_trip) begin
            s_nxt.therm_block = 1'b1;
        end else if (mon.temp_release) begin
            s_nxt.therm_block = 1'b0;
        end
        if (mon.boost_low && s_r.backlight_en) begin
            if (s_r.uv_cnt != P_BOOST_UNDERVOLTAGE_FLAG_CYCLES) begin
                s_nxt.uv_cnt = s_r.uv_cnt + 20'h00001;
            end
        end else begin
            s_nxt.uv_cnt = 20'h00000;
        end

        fault_set.supply_undervoltage_flag = mon.supply_low;
        fault_set.thermal_trip_flag = mon.temp_trip;
        fault_set.boost_overcurrent_flag = mon.boost_ilim;
        fault_set.boost_overvoltage_flag = mon.boost_clamp;
        fault_set.boost_undervoltage_flag = (s_r.uv_cnt == P_BOOST_UNDERVOLTAGE_FLAG_CYCLES);

        // serial port, closed until defaults are loaded
        if (s_r.mode == blsf_pkg::BLSF_MODE_LOAD) begin
            s_nxt.bus = blsf_pkg::BLSF_BUS_IDLE;
            s_nxt.sda_oe_n = 1'b1;
        end else if (start_c) begin
            s_nxt.bus = blsf_pkg::BLSF_BUS_ADDR;
            s_nxt.bit_cnt = 3'h0;
            s_nxt.byte_full = 1'b0;
            s_nxt.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            s_nxt.bus = blsf_pkg::BLSF_BUS_IDLE;
            s_nxt.sda_oe_n = 1'b1;
        end else begin
            case (s_r.bus)
                blsf_pkg::BLSF_BUS_ADDR, blsf_pkg::BLSF_BUS_RX: begin
                    if (scl_rise) begin
                        s_nxt.shift = {s_r.shift[6:0], pins.sda};
                        s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                        if (s_r.bit_cnt == 3'h7) begin
                            s_nxt.byte_full = 1'b1;
                        end
                    end else if (scl_fall && s_r.byte_full) begin
                        s_nxt.byte_full = 1'b0;
                        s_nxt.bit_cnt = 3'h0;
                        if (s_r.bus == blsf_pkg::BLSF_BUS_ADDR) begin
                            if (s_r.shift[7:1] == `BLSF_SLAVE_ADDR) begin
                                s_nxt.rw = s_r.shift[0];
                                s_nxt.ptr_phase = ~s_r.shift[0];
                                s_nxt.sda_oe_n = 1'b0;
                                s_nxt.bus = blsf_pkg::BLSF_BUS_ACK;
                            end else begin
                                s_nxt.bus = blsf_pkg::BLSF_BUS_IDLE;
                            end
                        end else begin
                            s_nxt.sda_oe_n = 1'b0;
                            s_nxt.bus = blsf_pkg::BLSF_BUS_ACK;
                            if (s_r.ptr_phase) begin
                                s_nxt.ptr = s_r.shift;
                                s_nxt.ptr_phase = 1'b0;
                            end else begin
                                wr_en = 1'b1;
                                s_nxt.ptr = s_r.ptr + 8'h01;
                            end
                        end
                    end
                end
                blsf_pkg::BLSF_BUS_ACK: begin
                    if (scl_fall) begin
                        s_nxt.sda_oe_n = 1'b1;
                        if (s_r.rw) begin
                            load_tx = 1'b1;
                        end else begin
                            s_nxt.bus = blsf_pkg::BLSF_BUS_RX;
                        end
                    end
                end
                blsf_pkg::BLSF_BUS_TX: begin
                    if (scl_fall) begin
                        if (s_r.bit_cnt == 3'h7) begin
                            s_nxt.sda_oe_n = 1'b1;
                            s_nxt.bus = blsf_pkg::BLSF_BUS_MACK;
                        end else begin
                            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                            s_nxt.shift = {s_r.shift[6:0], 1'b0};
                            s_nxt.sda_oe_n = s_r.shift[6];
                        end
                    end
                end
                blsf_pkg::BLSF_BUS_MACK: begin
                    if (scl_rise) begin
                        if (pins.sda) begin
                            s_nxt.bus = blsf_pkg::BLSF_BUS_IDLE;
                        end else begin
                            s_nxt.ptr = s_r.ptr + 8'h01;
                            s_nxt.byte_full = 1'b1;
                        end
                    end else if (scl_fall && s_r.byte_full) begin
                        s_nxt.byte_full = 1'b0;
                        load_tx = 1'b1;
                    end
                end
                default: begin
                    s_nxt.sda_oe_n = 1'b1;
                end
            endcase
        end

        // first read bit goes out at the falling edge that ends the ninth clock
        if (load_tx) begin
            s_nxt.shift = rd_byte;
            s_nxt.sda_oe_n = rd_byte[7];
            s_nxt.bit_cnt = 3'h0;
            s_nxt.bus = blsf_pkg::BLSF_BUS_TX;
            clear_faults = (s_r.ptr == `BLSF_REG_FAULT);
        end

        if (wr_en) begin
            if (s_r.ptr == `BLSF_REG_COMMAND) begin
                s_nxt.cmd = s_r.shift & `BLSF_CMD_MASK;
                soft_reset = s_r.shift[`BLSF_CMD_RESET_BIT];
            end else if (s_r.ptr == `BLSF_REG_MASK) begin
                s_nxt.mask = s_r.shift & `BLSF_MASK_MASK;
            end else if (s_r.ptr == `BLSF_REG_BRT_LO) begin
                s_nxt.brt[3:0] = s_r.shift[3:0];
            end else if (s_r.ptr == `BLSF_REG_BRT_HI) begin
                s_nxt.brt[11:4] = s_r.shift;
            end else if (s_r.ptr == `BLSF_REG_CONFIG) begin
                if (s_r.mode != blsf_pkg::BLSF_MODE_ACTIVE) begin
                    s_nxt.cfg = s_r.shift;
                end
            end
        end

        // a new event in the clearing cycle survives
        s_nxt.faults = (clear_faults ? '0 : s_r.faults) | fault_set;

        s_nxt.backlight_en = (s_nxt.mode == blsf_pkg::BLSF_MODE_ACTIVE)
            & ~s_nxt.uv_block & ~s_nxt.therm_block;

        // reset bit reloads defaults in place, so this byte still gets its ack; faults kept
        if (soft_reset) begin
            s_nxt.mode = blsf_pkg::BLSF_MODE_STANDBY;
            s_nxt.cmd = i_nv_command & `BLSF_CMD_MASK;
            s_nxt.cfg = i_nv_config;
            s_nxt.clamp_sel = i_nv_clamp_sel;
            s_nxt.backlight_en = 1'b0;
            s_nxt.brt = `BLSF_BRT_RST;
            s_nxt.mask = `BLSF_MASK_RST;
            s_nxt.pwm_seen = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !mon.chip_en) begin
            s_r <= '0;
            s_r.cmd <= `BLSF_CMD_RST;
            s_r.cfg <= `BLSF_CFG_RST;
            s_r.mask <= `BLSF_MASK_RST;
            s_r.brt <= `BLSF_BRT_RST;
            s_r.sda_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_serial_data_line_pin_o = s_r.sda_o;
    assign o_serial_data_line_pin_oe_n = s_r.sda_oe_n;
    assign o_backlight_en = s_r.backlight_en;
    assign o_mode = s_r.mode;
    assign o_faults = s_r.faults;
    assign o_brightness = s_r.brt;
    assign o_boost_clamp_sel = s_r.clamp_sel;
    assign o_phase_shifted_dimming = s_r.cfg[`BLSF_CFG_PSD_BIT];
endmodule

/* File: tb/blsf_i2c_master.sv */
`timescale 1ns/1ps
module blsf_i2c_master #(
    parameter int Q = 8
) (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe_n
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // one bus phase: lines move just after an edge, then hold
    task automatic hold(input logic c, input logic d);
        @(posedge i_clk);
        o_scl <= c;
        o_sda_oe_n <= d;
        repeat (Q) @(posedge i_clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        hold(1'b0, o_sda_oe_n);
        hold(1'b0, b);
        hold(1'b1, b);
        s = i_sda;
    endtask
    task automatic start();
        hold(1'b0, 1'b1);
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
    endtask
    task automatic stop();
        hold(1'b0, o_sda_oe_n);
        hold(1'b0, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, nack);
    endtask
    task automatic rbyte(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, s);
    endtask
endmodule

/* File: tb/blsf_properties.sv */
`timescale 1ns/1ps
module blsf_properties #(
    parameter logic [19:0] P_BOOST_UNDERVOLTAGE_FLAG_CYCLES = 20'h00014
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_enable_supply_pin,
    input wire logic i_serial_clock_line_pin,
    input wire logic i_supply_low,
    input wire logic i_temp_trip,
    input wire logic i_boost_ilim,
    input wire logic i_boost_clamp,
    input wire logic i_boost_low,
    input wire logic o_serial_data_line_pin_o,
    input wire logic o_serial_data_line_pin_oe_n,
    input wire logic o_backlight_en,
    input wire logic [1:0] o_mode,
    input wire logic [4:0] o_faults,
    input wire logic [11:0] o_brightness
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // cycles of boost low while lit, at the pins
    logic [19:0] low_cnt_r;
    always_ff @(posedge i_clk) begin
        if (i_rst || !(i_boost_low && o_backlight_en)) begin
            low_cnt_r <= 20'h00000;
        end else if (low_cnt_r != 20'hFFFFF) begin
            low_cnt_r <= low_cnt_r + 20'h00001;
        end
    end

    a_data_never_high: assert property (o_serial_data_line_pin_o == 1'b0)
        else $error("data line driven high");
    a_supply_trip: assert property ((i_supply_low && o_mode != 2'b00)[*8] |->
        o_faults[0] && !o_backlight_en) else $error("supply trip not handled");
    a_thermal_trip: assert property ((i_temp_trip && o_mode != 2'b00)[*8] |->
        o_faults[1] && !o_backlight_en) else $error("thermal trip not handled");
    a_overcurrent_flag: assert property ((i_boost_ilim && o_mode != 2'b00)[*8] |->
        o_faults[2]) else $error("overcurrent flag missing");
    a_overvoltage_flag: assert property ((i_boost_clamp && o_mode != 2'b00)[*8] |->
        o_faults[3]) else $error("overvoltage flag missing");
    a_boost_low_time: assert property ($rose(o_faults[4]) |->
        low_cnt_r >= P_BOOST_UNDERVOLTAGE_FLAG_CYCLES) else $error("boost low flag too early");
    a_flags_sticky: assert property ((i_chip_enable_supply_pin && i_serial_clock_line_pin)[*8]
        |-> ($past(o_faults) & ~o_faults) == 5'h00) else $error("flag cleared without read");
    a_drive_in_low: assert property ($changed(o_serial_data_line_pin_oe_n) &&
        i_chip_enable_supply_pin |-> !i_serial_clock_line_pin) else $error("data moved in high");
    a_ack_held: assert property ($fell(o_serial_data_line_pin_oe_n) |->
        (!o_serial_data_line_pin_oe_n)[*6]) else $error("low drive too short");
    a_enable_low_reset: assert property ((!i_chip_enable_supply_pin)[*6] |->
        o_mode == 2'b00 && o_faults == 5'h00 && !o_backlight_en && o_brightness == 12'h000)
        else $error("state kept with enable low");
    a_light_in_active: assert property (o_backlight_en |-> o_mode == 2'b10)
        else $error("light on outside active");
endmodule

bind blsf_top blsf_properties #(.P_BOOST_UNDERVOLTAGE_FLAG_CYCLES(P_BOOST_UNDERVOLTAGE_FLAG_CYCLES)) u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_chip_enable_supply_pin(i_chip_enable_supply_pin),
    .i_serial_clock_line_pin(i_serial_clock_line_pin), .i_supply_low(i_supply_low),
    .i_temp_trip(i_temp_trip), .i_boost_ilim(i_boost_ilim), .i_boost_clamp(i_boost_clamp),
    .i_boost_low(i_boost_low), .o_serial_data_line_pin_o(o_serial_data_line_pin_o),
    .o_serial_data_line_pin_oe_n(o_serial_data_line_pin_oe_n),
    .o_backlight_en(o_backlight_en), .o_mode(o_mode), .o_faults(o_faults),
    .o_brightness(o_brightness));

/* File: tb/blsf_top_bench.sv */
`timescale 1ns/1ps
module blsf_top_bench;
    localparam logic [19:0] P_UV = 20'h00014;
    logic clk;
    logic rst;
    logic chip_en;
    logic pwm;
    logic [3:0] trip;
    logic [1:0] rel;
    logic boost_low;
    logic [7:0] nv_cmd;
    logic [7:0] nv_cfg;
    logic [1:0] nv_clamp;
    logic scl;
    logic m_oe_n;
    logic s_o;
    logic s_oe_n;
    wire logic sda = m_oe_n & s_oe_n;
    logic [1:0] mode;
    logic [4:0] flt;
    logic [11:0] brt;
    logic [1:0] clsel;
    logic bl;
    logic psd;
    logic a;
    logic [7:0] d;
    logic [31:0] seed;
    logic [7:0] bad [3] = '{8'h5A, 8'h2C, 8'hD8};
    int m [256];
    int act;
    int err_total;
    int tests_run;

    blsf_top #(.P_BOOST_UNDERVOLTAGE_FLAG_CYCLES(P_UV)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_chip_enable_supply_pin(chip_en),
        .i_serial_clock_line_pin(scl), .i_serial_data_line_pin(sda),
        .o_serial_data_line_pin_o(s_o), .o_serial_data_line_pin_oe_n(s_oe_n), .i_pwm(pwm),
        .i_supply_low(trip[0]), .i_supply_above_hyst(rel[0]), .i_temp_trip(trip[1]),
        .i_temp_below_release(rel[1]), .i_boost_ilim(trip[2]), .i_boost_clamp(trip[3]),
        .i_boost_low(boost_low), .i_nv_command(nv_cmd), .i_nv_config(nv_cfg),
        .i_nv_clamp_sel(nv_clamp), .o_backlight_en(bl), .o_mode(mode), .o_faults(flt),
        .o_brightness(brt), .o_boost_clamp_sel(clsel), .o_phase_shifted_dimming(psd));
    blsf_i2c_master u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        #1;
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] q[$]);
        logic k;
        u_mst.start();
        u_mst.wbyte(8'h58, k);
        chk("write address ack", 12'h000, {11'h000, k});
        u_mst.wbyte(p, k);
        chk("pointer ack", 12'h000, {11'h000, k});
        foreach (q[i]) begin
            u_mst.wbyte(q[i], k);
            chk("data ack", 12'h000, {11'h000, k});
            case (p)
                8'h00: m[0] = q[i] & 8'h07;
                8'h02: m[2] = q[i] & 8'h1F;
                8'h03: m[3] = q[i] & 8'h0F;
                8'h04: m[4] = q[i];
                8'h10: m[16] = (act != 0) ? m[16] : q[i];
                default: ;
            endcase
            p++;
        end
        u_mst.stop();
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        logic k;
        logic [7:0] v;
        u_mst.start();
        u_mst.wbyte(8'h58, k);
        u_mst.wbyte(p, k);
        chk("pointer ack", 12'h000, {11'h000, k});
        u_mst.start();
        u_mst.wbyte(8'h59, k);
        chk("read address ack", 12'h000, {11'h000, k});
        for (int i = 0; i < n; i++) begin
            u_mst.rbyte(v, i == n - 1);
            chk("read data", 12'(m[p]), {4'h0, v});
            m[1] = (p == 8'h01) ? 0 : m[1];
            p++;
        end
        u_mst.stop();
    endtask
    task automatic trip_one(input int k);
        trip[k] <= 1'b1;
        if (k < 2) begin
            rel[k] <= 1'b0;
        end
        wt(10);
        trip[k] <= 1'b0;
        m[1] = m[1] | (1 << k);
        wt(10);
        chk("fault flag", 12'(m[1]), {7'h00, flt});
        if (k < 2) begin
            chk("light held off", 12'h000, {11'h000, bl});
            rel[k] <= 1'b1;
            wt(10);
        end
        chk("light back", 12'h001, {11'h000, bl});
    endtask

    initial begin
        wt(60000);
        err_total++;
        stop_test();
    end

    initial begin
        seed = 32'hD48419A7;
        err_total = 0;
        tests_run = 0;
        act = 0;
        rst = 1'b1;
        chip_en = 1'b1;
        pwm = 1'b0;
        trip = 4'h0;
        rel = 2'h3;
        boost_low = 1'b0;
        nv_cmd = rnd() & 8'h06;
        nv_cfg = (rnd() & 8'h3C) | 8'h01;
        nv_clamp = 2'(rnd());
        m[0] = nv_cmd;
        m[16] = nv_cfg;
        wt(16);
        rst <= 1'b0;
        wt(12);
        chk("mode", 12'h001, {10'h000, mode});
        chk("clamp select", {10'h000, nv_clamp}, {10'h000, clsel});
        chk("dimming bit", {11'h000, nv_cfg[5]}, {11'h000, psd});
        rd(8'h00, 5);
        foreach (bad[i]) begin
            u_mst.start();
            u_mst.wbyte(bad[i], a);
            u_mst.stop();
            chk("foreign ack", 12'h001, {11'h000, a});
        end
        wr(8'h03, {rnd(), rnd()});
        chk("brightness", 12'({m[4][7:0], m[3][3:0]}), brt);
        d = (rnd() & 8'h3C) | 8'h02;
        wr(8'h10, {d});
        chk("dimming bit", {11'h000, d[5]}, {11'h000, psd});
        for (int i = 0; i < 3; i++) begin
            wr(8'h02, {rnd()});
            rd(8'h02, 1);
        end
        wr(8'h00, {8'h01});
        act = 1;
        wt(8);
        chk("mode", 12'h002, {10'h000, mode});
        chk("light", 12'h001, {11'h000, bl});
        wr(8'h10, {~d});
        rd(8'h10, 1);
        wr(8'h03, {rnd(), rnd()});
        chk("brightness", 12'({m[4][7:0], m[3][3:0]}), brt);
        for (int k = 0; k < 4; k++) begin
            trip_one(k);
        end
        boost_low <= 1'b1;
        wt(int'(P_UV) - 6);
        boost_low <= 1'b0;
        wt(8);
        chk("short boost dip", 12'(m[1]), {7'h00, flt});
        boost_low <= 1'b1;
        wt(int'(P_UV) + 12);
        boost_low <= 1'b0;
        m[1] = m[1] | 16;
        wt(8);
        chk("sticky flags", 12'h01F, {7'h00, flt});
        rd(8'h01, 1);
        chk("flags cleared", 12'h000, {7'h00, flt});
        wr(8'h00, {8'h00});
        act = 0;
        wt(8);
        chk("mode", 12'h001, {10'h000, mode});
        chk("light", 12'h000, {11'h000, bl});
        wr(8'h10, {8'h80});
        pwm <= 1'b1;
        wt(12);
        chk("pwm mode", 12'h002, {10'h000, mode});
        chk("pwm light", 12'h001, {11'h000, bl});
        pwm <= 1'b0;
        wt(12);
        chk("pwm standby", 12'h001, {10'h000, mode});
        wr(8'h00, {8'h80});
        m[0] = nv_cmd;
        m[16] = nv_cfg;
        m[2] = 0;
        chk("reset brightness", 12'h000, brt);
        rd(8'h00, 3);
        chk("reset dimming bit", {11'h000, nv_cfg[5]}, {11'h000, psd});
        chip_en <= 1'b0;
        wt(10);
        chk("off mode", 12'h000, {10'h000, mode});
        chk("off brightness", 12'h000, brt);
        stop_test();
    end
endmodule
